/* pkg/sgc_pkg.sv */
package sgc_pkg;

  // ******************************
  // Register map
  // ******************************
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam logic [REG_AW-1:0] ADDR_GC4 = 8'h06;
  localparam logic [REG_AW-1:0] ADDR_STORM_LOW = 8'h07;
  localparam logic [REG_AW-1:0] ADDR_TEST_A = 8'h08;
  localparam logic [REG_AW-1:0] ADDR_TEST_B = 8'h09;
  localparam logic [REG_AW-1:0] ADDR_TEST_C = 8'h0a;

  // ******************************
  // Fields of global_control_four
  // ******************************
  localparam int BIT_REPEATER = 7;
  localparam int BIT_HALF_DUPLEX = 6;
  localparam int BIT_FLOW_CTRL = 5;
  localparam int BIT_SPEED_10 = 4;
  localparam int BIT_VID_SUB = 3;
  localparam int STORM_HI_MSB = 2;
  localparam int STORM_HI_W = 3;
  localparam int STORM_W = 11;

  // ******************************
  // Reset values
  // ******************************
  localparam logic [REG_DW-1:0] RST_GC4 = 8'h00;
  localparam logic [REG_DW-1:0] RST_STORM_LOW = 8'h63;
  localparam logic [REG_DW-1:0] RST_TEST_A = 8'h00;
  localparam logic [REG_DW-1:0] RST_TEST_B = 8'h24;
  localparam logic [REG_DW-1:0] RST_TEST_C = 8'h35;
  localparam logic [REG_DW-1:0] RDATA_NONE = 8'h00;

  // ******************************
  // VLAN and storm timing
  // ******************************
  localparam int VID_W = 12;
  localparam logic [VID_W-1:0] NULL_VID = 12'h000;
  localparam int STORM_BLOCK_BYTES = 64;
  localparam int CLK_FREQ_KHZ = 100_000;
  localparam int PERIOD_100M_MS = 67;
  localparam int PERIOD_10M_MS = 500;
  localparam int PERIOD_100M_CYC = PERIOD_100M_MS * CLK_FREQ_KHZ;
  localparam int PERIOD_10M_CYC = PERIOD_10M_MS * CLK_FREQ_KHZ;
  localparam int TIMER_W = 26;
  localparam int NPORTS = 3;

  typedef enum logic [1:0] {
    SGC_ST_STRAP = 2'b00,
    SGC_ST_RUN = 2'b01
  } sgc_state_type;

  function automatic logic [STORM_W-1:0] storm_threshold(
    input logic [REG_DW-1:0] gc4,
    input logic [REG_DW-1:0] low
  );
    return {gc4[STORM_HI_MSB:0], low};
  endfunction : storm_threshold

endpackage : sgc_pkg

/* pkg/sgc_storm_if.sv */
`timescale 1ns/1ps
interface sgc_storm_if #(
  parameter int NP = sgc_pkg::NPORTS
);
  logic [sgc_pkg::STORM_W-1:0] threshold;
  logic [NP-1:0] period_start;
  logic [NP-1:0] block_seen;
  logic [NP-1:0] drop;

  modport meter (
    input threshold,
    input period_start,
    input block_seen,
    output drop
  );
  modport ctrl (
    output threshold,
    output period_start,
    output block_seen,
    input drop
  );
endinterface : sgc_storm_if

/* design/sgc_storm_meter.sv */
`timescale 1ns/1ps
module sgc_storm_meter #(
  parameter int NP = sgc_pkg::NPORTS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  sgc_storm_if.meter st
);
  import sgc_pkg::*;

  logic [STORM_W-1:0] cnt_q [NP];
  logic [STORM_W-1:0] cnt_d [NP];
  logic [NP-1:0] gate;

  // ******************************
  // Per-port block counters
  // ******************************
  // The count saturates at the threshold, so it never wraps into a
  // fresh allowance within one period. The drop flag comes from the
  // count after this edge, so once registered at the top it matches
  // the gate that the meter applies in the next cycle.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      gate[p] = (cnt_q[p] >= st.threshold); // see RULE12
      if (st.period_start[p]) begin // see RULE12
        cnt_d[p] = (st.block_seen[p] && !gate[p]) ? STORM_W'(1) : '0;
      end else if (st.block_seen[p] && !gate[p]) begin // see RULE8
        cnt_d[p] = cnt_q[p] + STORM_W'(1);
      end else begin
        cnt_d[p] = cnt_q[p];
      end
      st.drop[p] = (cnt_d[p] >= st.threshold); // see RULE12
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < NP; p++) begin
        cnt_q[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        cnt_q[p] <= cnt_d[p];
      end
    end
  end

  // ******************************
  // Checks
  // ******************************
  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
    st.period_start[0] && !st.block_seen[0] |=> cnt_q[0] == '0;
  endproperty
  a_restart: assert property (p_restart) // see RULE12
    else $error("storm count not restarted at period start");

  property p_count_block;
    @(posedge clk_i) disable iff (rst_i)
    !st.period_start[0] && st.block_seen[0] && !gate[0]
      |=> cnt_q[0] == $past(cnt_q[0]) + STORM_W'(1);
  endproperty
  a_count_block: assert property (p_count_block) // see RULE8
    else $error("accepted 64-byte block not counted");

  property p_hold_at_limit;
    @(posedge clk_i) disable iff (rst_i)
    st.drop[0] ##1 (!st.period_start[0] && $stable(st.threshold))
      |-> st.drop[0];
  endproperty
  a_hold_at_limit: assert property (p_hold_at_limit) // see RULE12
    else $error("discard released before period end");

endmodule : sgc_storm_meter

/* design/sgc_global_ctrl.sv */
// Functional notes
// RULE1: Bit 7 of control four enables repeater mode; resets to zero.
// RULE2: Software sets all ports to 100BASE-TX half duplex before repeater.
// RULE3: Software keeps auto-negotiation off on both PHYs during repeater.
// RULE4: Bit 6 selects MII half duplex; reset value taken from duplex strap.
// RULE5: Bit 5 enables MII flow control; reset value taken from flow strap.
// RULE6: Bit 4 selects 10 Mbps on MII; reset value from speed strap.
// RULE7: Bit 3 replaces a null VLAN ID with the port default ID.
// RULE8: Storm threshold counts 64-byte blocks allowed per port per period.
// RULE9: Storm period is 67 ms at 100 Mbps, 500 ms at 10 Mbps.
// RULE10: Threshold is 11 bits: control four bits 2:0, storm low 7:0; 0x63.
// RULE11: Test registers reset to 0x00, 0x24, 0x35; software leaves them.
// RULE12: Block count restarts each period; excess broadcast is discarded.
`timescale 1ns/1ps
module sgc_global_ctrl #(
  parameter int NP = sgc_pkg::NPORTS,
  parameter int PERIOD_100M_CYC = sgc_pkg::PERIOD_100M_CYC,
  parameter int PERIOD_10M_CYC = sgc_pkg::PERIOD_10M_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [sgc_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [sgc_pkg::REG_DW-1:0] reg_wdata_i,
  output logic [sgc_pkg::REG_DW-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic duplex_strap_pin_i,
  input wire logic flow_ctrl_strap_pin_i,
  input wire logic speed_strap_pin_i,
  input wire logic [NP-1:0] port_speed_10_i,
  input wire logic [NP-1:0] bcast_block_i,
  output logic [NP-1:0] storm_drop_o,
  input wire logic rx_vid_valid_i,
  input wire logic [sgc_pkg::VID_W-1:0] rx_vid_i,
  input wire logic [sgc_pkg::VID_W-1:0] rx_port_vid_i,
  output logic vid_valid_o,
  output logic [sgc_pkg::VID_W-1:0] vid_o,
  output logic repeater_en_o,
  output logic mii_half_duplex_o,
  output logic mii_flow_ctrl_o,
  output logic mii_speed_10_o,
  output logic [sgc_pkg::STORM_W-1:0] storm_threshold_o
);
  import sgc_pkg::*;

  localparam logic [TIMER_W-1:0] LIMIT_100 = TIMER_W'(PERIOD_100M_CYC - 1);
  localparam logic [TIMER_W-1:0] LIMIT_10 = TIMER_W'(PERIOD_10M_CYC - 1);

  sgc_state_type state_q;
  sgc_state_type state_d;
  logic [REG_DW-1:0] gc4_q;
  logic [REG_DW-1:0] storm_low_q;
  logic [REG_DW-1:0] test_a_q;
  logic [REG_DW-1:0] test_b_q;
  logic [REG_DW-1:0] test_c_q;
  logic [TIMER_W-1:0] timer_q [NP];
  logic [NP-1:0] tick_q;

  sgc_storm_if #(.NP(NP)) st_if ();

  // ******************************
  // Register decode
  // ******************************
  wire wr_gc4 = reg_wr_i && (reg_addr_i == ADDR_GC4);
  wire wr_storm_low = reg_wr_i && (reg_addr_i == ADDR_STORM_LOW);
  wire wr_test_a = reg_wr_i && (reg_addr_i == ADDR_TEST_A);
  wire wr_test_b = reg_wr_i && (reg_addr_i == ADDR_TEST_B);
  wire wr_test_c = reg_wr_i && (reg_addr_i == ADDR_TEST_C);
  wire strap_phase = (state_q == SGC_ST_STRAP);
  wire [REG_DW-1:0] rdata_sel =
    (reg_addr_i == ADDR_GC4) ? gc4_q :
    (reg_addr_i == ADDR_STORM_LOW) ? storm_low_q :
    (reg_addr_i == ADDR_TEST_A) ? test_a_q :
    (reg_addr_i == ADDR_TEST_B) ? test_b_q :
    (reg_addr_i == ADDR_TEST_C) ? test_c_q : RDATA_NONE;
  wire [STORM_W-1:0] threshold = storm_threshold(gc4_q, storm_low_q);
  wire vid_is_null = (rx_vid_i == NULL_VID);
  wire vid_sub = gc4_q[BIT_VID_SUB] && vid_is_null;

  // ******************************
  // Strap capture sequencing
  // ******************************
  // Straps cannot be loaded under the asynchronous reset, so they are
  // caught on the first edge after release.
  always_comb begin
    case (state_q)
      SGC_ST_STRAP: state_d = SGC_ST_RUN;
      SGC_ST_RUN: state_d = SGC_ST_RUN;
      default: state_d = SGC_ST_STRAP;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SGC_ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  // ******************************
  // Registers
  // ******************************
  // A write landing in the strap cycle loses to the strap load.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gc4_q <= RST_GC4; // see RULE1
    end else if (strap_phase) begin
      gc4_q[BIT_HALF_DUPLEX] <= duplex_strap_pin_i; // see RULE4
      gc4_q[BIT_FLOW_CTRL] <= flow_ctrl_strap_pin_i; // see RULE5
      gc4_q[BIT_SPEED_10] <= speed_strap_pin_i; // see RULE6
    end else if (wr_gc4) begin
      gc4_q <= reg_wdata_i; // see RULE1
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      storm_low_q <= RST_STORM_LOW; // see RULE10
      test_a_q <= RST_TEST_A; // see RULE11
      test_b_q <= RST_TEST_B; // see RULE11
      test_c_q <= RST_TEST_C; // see RULE11
    end else begin
      if (wr_storm_low) begin
        storm_low_q <= reg_wdata_i;
      end
      // Test registers stay writable; their content steers nothing here.
      if (wr_test_a) begin
        test_a_q <= reg_wdata_i;
      end
      if (wr_test_b) begin
        test_b_q <= reg_wdata_i;
      end
      if (wr_test_c) begin
        test_c_q <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= RDATA_NONE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_sel : RDATA_NONE;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ******************************
  // Configuration outputs
  // ******************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      repeater_en_o <= 1'b0;
      mii_half_duplex_o <= 1'b0;
      mii_flow_ctrl_o <= 1'b0;
      mii_speed_10_o <= 1'b0;
      storm_threshold_o <= '0;
    end else begin
      repeater_en_o <= gc4_q[BIT_REPEATER]; // see RULE1
      mii_half_duplex_o <= gc4_q[BIT_HALF_DUPLEX]; // see RULE4
      mii_flow_ctrl_o <= gc4_q[BIT_FLOW_CTRL]; // see RULE5
      mii_speed_10_o <= gc4_q[BIT_SPEED_10]; // see RULE6
      storm_threshold_o <= threshold; // see RULE10
    end
  end

  // ******************************
  // Null VLAN ID substitution
  // ******************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_valid_o <= 1'b0;
      vid_o <= NULL_VID;
    end else begin
      vid_valid_o <= rx_vid_valid_i;
      if (rx_vid_valid_i) begin
        vid_o <= vid_sub ? rx_port_vid_i : rx_vid_i; // see RULE7
      end
    end
  end

  // ******************************
  // Storm measurement periods
  // ******************************
  // Each port times its own period; a speed change takes effect at once,
  // and a timer past the new limit simply ends the period early.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < NP; p++) begin
        timer_q[p] <= '0;
      end
      tick_q <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (timer_q[p] >= (port_speed_10_i[p] ? LIMIT_10 : LIMIT_100)) begin
          timer_q[p] <= '0; // see RULE9
          tick_q[p] <= 1'b1;
        end else begin
          timer_q[p] <= timer_q[p] + TIMER_W'(1);
          tick_q[p] <= 1'b0;
        end
      end
    end
  end

  assign st_if.threshold = threshold; // see RULE8
  assign st_if.period_start = tick_q;
  assign st_if.block_seen = bcast_block_i;

  sgc_storm_meter #(.NP(NP)) u_meter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .st(st_if.meter)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      storm_drop_o <= '0;
    end else begin
      storm_drop_o <= st_if.drop; // see RULE12
    end
  end

  // ******************************
  // Checks
  // ******************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_gc4_write;
    !strap_phase && wr_gc4;
  endsequence

  property p_repeater;
    s_gc4_write ##1 1'b1
      |=> repeater_en_o == $past(reg_wdata_i[BIT_REPEATER], 2);
  endproperty
  a_repeater: assert property (p_repeater) // see RULE1
    else $error("repeater enable does not follow write");

  // The release edge still samples reset high, which keeps it out
  sequence s_strap;
    strap_phase && !rst_i;
  endsequence

  property p_duplex_strap;
    s_strap |=> ##1 mii_half_duplex_o == $past(duplex_strap_pin_i, 2);
  endproperty
  a_duplex_strap: assert property (p_duplex_strap) // see RULE4
    else $error("half duplex not loaded from strap");

  property p_flow_strap;
    s_strap |=> ##1 mii_flow_ctrl_o == $past(flow_ctrl_strap_pin_i, 2);
  endproperty
  a_flow_strap: assert property (p_flow_strap) // see RULE5
    else $error("flow control not loaded from strap");

  property p_speed_strap;
    s_strap |=> gc4_q[BIT_SPEED_10] == $past(speed_strap_pin_i);
  endproperty
  a_speed_strap: assert property (p_speed_strap) // see RULE6
    else $error("speed not loaded from strap");

  property p_vid_sub;
    rx_vid_valid_i && gc4_q[BIT_VID_SUB] && rx_vid_i == NULL_VID
      |=> vid_valid_o && vid_o == $past(rx_port_vid_i);
  endproperty
  a_vid_sub: assert property (p_vid_sub) // see RULE7
    else $error("null VLAN ID not substituted");

  property p_vid_pass;
    rx_vid_valid_i && !gc4_q[BIT_VID_SUB] |=> vid_o == $past(rx_vid_i);
  endproperty
  a_vid_pass: assert property (p_vid_pass) // see RULE7
    else $error("VLAN ID altered with substitution off");

  property p_threshold;
    !rst_i |=> storm_threshold_o ==
      {$past(gc4_q[STORM_HI_MSB:0]), $past(storm_low_q)};
  endproperty
  a_threshold: assert property (p_threshold) // see RULE10
    else $error("storm threshold mis-assembled");

  property p_test_b_hold;
    !$past(wr_test_b) |-> $stable(test_b_q);
  endproperty
  a_test_b_hold: assert property (p_test_b_hold) // see RULE11
    else $error("factory test register changed without a write");

  property p_test_a_hold;
    !$past(wr_test_a) |-> $stable(test_a_q);
  endproperty
  a_test_a_hold: assert property (p_test_a_hold) // see RULE11
    else $error("factory test register a changed without a write");

  property p_test_c_hold;
    !$past(wr_test_c) |-> $stable(test_c_q);
  endproperty
  a_test_c_hold: assert property (p_test_c_hold) // see RULE11
    else $error("factory test register c changed without a write");

  property p_period;
    tick_q[0] |-> timer_q[0] == '0 ##1 timer_q[0] == TIMER_W'(1);
  endproperty
  a_period: assert property (p_period) // see RULE9
    else $error("storm period timer not restarted");

endmodule : sgc_global_ctrl

/* bench/sgc_global_ctrl_tb.sv */
`timescale 1ns/1ps
module sgc_global_ctrl_tb;
  import sgc_pkg::*;

  localparam int P100 = 20;
  localparam int P10 = 40;
  localparam int THR = 3;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [REG_AW-1:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [REG_DW-1:0] reg_wdata_i = 8'h00;
  logic [REG_DW-1:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic duplex_strap_pin_i = 1'b0;
  logic flow_ctrl_strap_pin_i = 1'b0;
  logic speed_strap_pin_i = 1'b0;
  logic [NPORTS-1:0] port_speed_10_i = 3'b000;
  logic [NPORTS-1:0] bcast_block_i = 3'b000;
  logic [NPORTS-1:0] storm_drop_o;
  logic rx_vid_valid_i = 1'b0;
  logic [VID_W-1:0] rx_vid_i = 12'h000;
  logic [VID_W-1:0] rx_port_vid_i = 12'h000;
  logic vid_valid_o;
  logic [VID_W-1:0] vid_o;
  logic repeater_en_o;
  logic mii_half_duplex_o;
  logic mii_flow_ctrl_o;
  logic mii_speed_10_o;
  logic [STORM_W-1:0] storm_threshold_o;
  int miscompares = 0;
  int compares = 0;

  always #5 clk_i = ~clk_i;

  // Short periods keep the storm checks to a few hundred cycles
  sgc_global_ctrl #(
    .NP(NPORTS),
    .PERIOD_100M_CYC(P100),
    .PERIOD_10M_CYC(P10)
  ) DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .duplex_strap_pin_i(duplex_strap_pin_i),
    .flow_ctrl_strap_pin_i(flow_ctrl_strap_pin_i),
    .speed_strap_pin_i(speed_strap_pin_i),
    .port_speed_10_i(port_speed_10_i),
    .bcast_block_i(bcast_block_i),
    .storm_drop_o(storm_drop_o),
    .rx_vid_valid_i(rx_vid_valid_i),
    .rx_vid_i(rx_vid_i),
    .rx_port_vid_i(rx_port_vid_i),
    .vid_valid_o(vid_valid_o),
    .vid_o(vid_o),
    .repeater_en_o(repeater_en_o),
    .mii_half_duplex_o(mii_half_duplex_o),
    .mii_flow_ctrl_o(mii_flow_ctrl_o),
    .mii_speed_10_o(mii_speed_10_o),
    .storm_threshold_o(storm_threshold_o)
  );

  // ******************************
  // Checking and closing
  // ******************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen,
               exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ******************************
  // Bus and stimulus tasks
  // ******************************
  task automatic do_reset(input logic [2:0] straps);
    @(posedge clk_i);
    rst_i <= 1'b1;
    {duplex_strap_pin_i, flow_ctrl_strap_pin_i, speed_strap_pin_i} <= straps;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Edge one after release belongs to the strap capture
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= addr;
    reg_wdata_i <= data;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= addr;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    check({15'h0000, reg_rvalid_o}, 16'h0001, "read valid");
    check({8'h00, reg_rdata_o}, {8'h00, exp}, "read data");
  endtask : rd_chk

  // Config outputs trail the register by one cycle
  task automatic cfg_chk(input logic [3:0] exp);
    @(posedge clk_i);
    @(negedge clk_i);
    check({12'h000, repeater_en_o, mii_half_duplex_o, mii_flow_ctrl_o,
           mii_speed_10_o}, {12'h000, exp}, "config outputs");
  endtask : cfg_chk

  task automatic vid_chk(input logic [11:0] vin, input logic [11:0] pvid,
                         input logic [11:0] exp);
    @(posedge clk_i);
    rx_vid_valid_i <= 1'b1;
    rx_vid_i <= vin;
    rx_port_vid_i <= pvid;
    @(posedge clk_i);
    rx_vid_valid_i <= 1'b0;
    @(negedge clk_i);
    check({15'h0000, vid_valid_o}, 16'h0001, "vid valid");
    check({4'h0, vid_o}, {4'h0, exp}, "vid value");
  endtask : vid_chk

  // Streams blocks without pause, then measures period and pass window
  task automatic storm_run(input int p, input int per);
    int n;
    int lo;
    logic prev;
    @(posedge clk_i);
    bcast_block_i[p] <= 1'b1;
    @(negedge clk_i);
    n = 0;
    do begin
      prev = storm_drop_o[p];
      @(negedge clk_i);
      n++;
    end while (!(prev === 1'b1 && storm_drop_o[p] === 1'b0) && n < 400);
    lo = 0;
    while (storm_drop_o[p] === 1'b0 && lo < 400) begin
      @(negedge clk_i);
      lo++;
    end
    n = lo;
    do begin
      prev = storm_drop_o[p];
      @(negedge clk_i);
      n++;
    end while (!(prev === 1'b1 && storm_drop_o[p] === 1'b0) && n < 400);
    check(n[15:0], per[15:0], "storm period");
    check({15'h0000, lo >= THR && lo <= THR + 1}, 16'h0001, "pass window");
    check({15'h0000, storm_drop_o[2]}, 16'h0000, "idle port dropping");
    @(posedge clk_i);
    bcast_block_i[p] <= 1'b0;
  endtask : storm_run

  // ******************************
  // Watchdog and main sequence
  // ******************************
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test();
  end

  initial begin
    do_reset(3'b000);
    rd_chk(ADDR_GC4, RST_GC4);
    cfg_chk(4'b0000);
    rd_chk(ADDR_STORM_LOW, RST_STORM_LOW);
    check(16'(storm_threshold_o), 16'(RST_STORM_LOW), "thr");
    rd_chk(ADDR_TEST_A, RST_TEST_A);
    rd_chk(ADDR_TEST_B, RST_TEST_B);
    rd_chk(ADDR_TEST_C, RST_TEST_C);
    rd_chk(8'h0b, RDATA_NONE);
    for (int b = BIT_VID_SUB; b <= BIT_HALF_DUPLEX; b++) begin
      wr(ADDR_GC4, 8'h01 << b);
      rd_chk(ADDR_GC4, 8'h01 << b);
      cfg_chk(4'(8'h01 << b >> 4));
    end
    // Repeater only with every port at 100 Mbps half duplex and no
    // autonegotiation ever started from this side
    wr(ADDR_GC4, 8'hc0);
    rd_chk(ADDR_GC4, 8'hc0);
    cfg_chk(4'b1100);
    wr(ADDR_GC4, 8'h05);
    wr(ADDR_STORM_LOW, 8'h3c);
    cfg_chk(4'b0000);
    check({5'h00, storm_threshold_o}, 16'h053c, "thr split");
    vid_chk(12'h000, 12'h123, 12'h000);
    wr(ADDR_GC4, 8'h08);
    vid_chk(12'h000, 12'h123, 12'h123);
    vid_chk(12'h456, 12'h123, 12'h456);
    do_reset(3'b111);
    port_speed_10_i <= 3'b010;
    rd_chk(ADDR_GC4, 8'h70);
    cfg_chk(4'b0111);
    wr(ADDR_GC4, 8'h00);
    wr(ADDR_STORM_LOW, 8'(THR));
    storm_run(0, P100);
    storm_run(1, P10);
    // A zero threshold leaves no room for any broadcast block
    wr(ADDR_STORM_LOW, 8'h00);
    repeat (P10 + 4) @(posedge clk_i);
    @(negedge clk_i);
    check({13'h0000, storm_drop_o}, 16'h0007, "zero thr");
    end_of_test();
  end

endmodule : sgc_global_ctrl_tb
